// [src/spt_core.sv]
// step angle, phase current table and diagnostic fault logic
// Overview of operation
// [RULE1] decay selector: slow, mixed fixed, mixed auto, fast
// [RULE2] step delta is signed, added to angle
// [RULE3] angle indexes 64 positions, 0 to 63
// [RULE4] sixteen microsteps per step, four per cycle
// [RULE5] table word: 11 tag, odd parity, magnitude
// [RULE6] sixteen entries shared by symmetry over angles
// [RULE7] zero and last entry at quarter points
// [RULE8] each angle step is 5.625 degrees
// [RULE9] each phase reference is six bits
// [RULE10] fault register 0 bit order fixed
// [RULE11] fault register 1 adds angle readback
// [RULE12] thermal code: none, cold, hot, shutdown
// [RULE13] supply high and supply low flags
// [RULE14] stall and per-phase open load flags
// [RULE15] controller spaces step pulses and strobe
// [RULE16] motion only by changing the angle
// [RULE17] angle updates wrap modulo 64
// [RULE18] summary flag covers faults and serial errors
// [RULE19] diagnostics clear per access and reset pin
// [RULE20] table survives reset pin, not power-on
// [RULE21] phase current signs per half cycle
// [RULE22] even parity table word rejected and flagged
`timescale 1ns/1ps
module spt_core
	import spt_pkg::*;
#(
	parameter int RST_LOW_CYCLES = RST_CYCLES
)(
	input  wire logic               sys_clk_i,
	input  wire logic               rstn_i,
	input  wire logic               reset_pin_n_i,
	input  wire logic [WORD_W-1:0]  ser_word_i,
	input  wire logic               ser_write_i,
	input  wire logic               ser_access_done_i,
	input  wire logic               ser_write_err_i,
	input  wire logic               step_i,
	input  wire logic               dir_i,
	input  wire logic [1:0]         microstep_i,
	input  wire logic [1:0]         thermal_i,
	input  wire logic               supply_high_i,
	input  wire logic               motor_supply_low_i,
	input  wire logic               regulator_supply_low_i,
	input  wire logic               rotor_halt_i,
	input  wire logic               open_load_a_i,
	input  wire logic               open_load_b_i,
	input  wire logic [7:0]         overcurrent_i,
	output logic [1:0]              decay_select_o,
	output logic [ANGLE_W-1:0]      step_angle_o,
	output logic [MAG_W-1:0]        phase_a_mag_o,
	output logic                    phase_a_neg_o,
	output logic [MAG_W-1:0]        phase_b_mag_o,
	output logic                    phase_b_neg_o,
	output logic [WORD_W-1:0]       fault_flags_primary_o,
	output logic [WORD_W-1:0]       fault_flags_with_angle_o,
	output logic                    parity_err_o
);

	spt_table_if tbl ();

	logic [ANGLE_W-1:0] step_angle;
	logic [1:0]         decay_select;
	logic [14:0]        fault_bits;
	logic               serial_err;
	logic               step_prev;
	logic [RST_CNT_W-1:0] rst_low_cnt;
	logic               pin_clear;
	logic               diag_clear;
	logic               is_run;
	logic               is_table;
	logic               parity_ok;
	logic [IDX_W-1:0]   load_idx;
	logic               step_edge;
	logic [ANGLE_W-1:0] grid;
	logic [ANGLE_W-1:0] offset;
	logic [ANGLE_W-1:0] rel;
	logic [ANGLE_W-1:0] next_angle;
	logic [ANGLE_W-1:0] angle_b;
	logic [14:0]        fault_events;

	// ----------------------------------------------------------------
	// word decode
	// ----------------------------------------------------------------
	assign is_run    = ser_write_i && ser_word_i[ID_HI:ID_LO] == ID_RUN;
	assign is_table  = ser_write_i && ser_word_i[ID_HI:ID_LO] == ID_TABLE; // [RULE5]
	assign parity_ok = ^ser_word_i; // odd count of ones [RULE22]

	// reset pin held low long enough
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_low_cnt <= '0;
			pin_clear   <= 1'b0;
		end else if (reset_pin_n_i) begin
			rst_low_cnt <= '0;
			pin_clear   <= 1'b0;
		end else if (rst_low_cnt >= RST_CNT_W'(RST_LOW_CYCLES - 1)) begin
			pin_clear   <= 1'b1;
		end else begin
			rst_low_cnt <= rst_low_cnt + 1'b1;
		end
	end

	assign diag_clear = ser_access_done_i || pin_clear; // [RULE19]

	// ----------------------------------------------------------------
	// decay selection
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			decay_select <= DECAY_RESET; // mixed, fixed fast time [RULE1]
		end else if (pin_clear) begin
			decay_select <= DECAY_RESET;
		end else if (is_run) begin
			decay_select <= ser_word_i[DECAY_HI:DECAY_LO]; // [RULE1]
		end
	end

	// ----------------------------------------------------------------
	// step pulse translator
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			step_prev <= 1'b0;
		end else begin
			step_prev <= step_i;
		end
	end

	assign step_edge = step_i && !step_prev;

	// grid spacing and offset per microstep mode
	always_comb begin
		offset = '0;
		case (spt_microstep_e'(microstep_i))
			SPT_MS_FULL: begin
				grid   = QUARTER;
				offset = FULL_OFFSET;
			end
			SPT_MS_HALF:    grid = 6'h08;
			SPT_MS_QUARTER: grid = 6'h04;
			default:        grid = 6'h01; // sixteenth [RULE4]
		endcase
	end

	// next grid position, moving off-grid angles to the next one in the step direction
	always_comb begin
		rel = step_angle - offset;
		if (dir_i) begin
			next_angle = (rel & ~(grid - 6'h01)) + grid + offset; // [RULE17]
		end else if ((rel & (grid - 6'h01)) == 6'h00) begin
			next_angle = rel - grid + offset; // [RULE17]
		end else begin
			next_angle = (rel & ~(grid - 6'h01)) + offset;
		end
	end

	// ----------------------------------------------------------------
	// step angle number, 5.625 degrees per count
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			step_angle <= ANGLE_RESET;
		end else if (pin_clear) begin
			step_angle <= ANGLE_RESET;
		end else if (is_run) begin
			// signed delta, 6-bit sum wraps [RULE2] [RULE16] [RULE17] [RULE3] [RULE8]
			step_angle <= step_angle + ser_word_i[DELTA_HI:DELTA_LO];
		end else if (step_edge) begin
			step_angle <= next_angle; // [RULE16] [RULE15]
		end
	end

	// ----------------------------------------------------------------
	// table load
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			load_idx <= '0;
		end else if (pin_clear) begin
			load_idx <= '0;
		end else if (is_table && parity_ok) begin
			load_idx <= load_idx + 1'b1;
		end
	end

	assign tbl.wr_en  = is_table && parity_ok; // [RULE22] [RULE20]
	assign tbl.wr_idx = load_idx;
	assign tbl.wr_mag = ser_word_i[ENTRY_HI:ENTRY_LO]; // [RULE9]

	// entry lookup by half-cycle symmetry
	function automatic logic [IDX_W-1:0] entry_of(input logic [ANGLE_W-1:0] ang);
		logic [4:0] p;
		p = ang[4:0];
		if (p <= HALF_PEAK) begin
			entry_of = IDX_W'(p - 5'h01); // rising quarter [RULE6]
		end else begin
			entry_of = IDX_W'(HALF_MIRROR - p); // falling quarter [RULE6]
		end
	endfunction

	assign angle_b      = step_angle + QUARTER; // phase B leads by a quarter
	assign tbl.rd_idx_a = entry_of(step_angle);
	assign tbl.rd_idx_b = entry_of(angle_b);

	spt_table_mem u_mem (
		.sys_clk_i (sys_clk_i),
		.rstn_i    (rstn_i),
		.tbl       (tbl.mem)
	);

	// signs and zero points, aligned with the registered reads
	logic zero_a, neg_a;
	logic zero_b, neg_b;
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			zero_a <= 1'b1;
			zero_b <= 1'b0;
			neg_a  <= 1'b0;
			neg_b  <= 1'b0;
		end else begin
			zero_a <= step_angle[4:0] == HALF_ZERO; // [RULE7]
			zero_b <= angle_b[4:0] == HALF_ZERO; // [RULE7]
			neg_a  <= step_angle[5] && step_angle[4:0] != HALF_ZERO; // [RULE21]
			neg_b  <= angle_b[5] && angle_b[4:0] != HALF_ZERO; // [RULE21]
		end
	end

	// sign and magnitude leave together, so no wrong-sign cycle
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			{phase_a_neg_o, phase_a_mag_o} <= '0;
			{phase_b_neg_o, phase_b_mag_o} <= '0;
		end else begin
			{phase_a_neg_o, phase_a_mag_o} <= {neg_a, (zero_a ? 6'h00 : tbl.rd_mag_a)}; // [RULE7] [RULE9]
			{phase_b_neg_o, phase_b_mag_o} <= {neg_b, (zero_b ? 6'h00 : tbl.rd_mag_b)}; // [RULE7] [RULE9]
		end
	end

	// ----------------------------------------------------------------
	// diagnostics
	// ----------------------------------------------------------------
	assign fault_events = {
		thermal_i,                                   // [RULE12]
		supply_high_i,                               // [RULE13]
		motor_supply_low_i | regulator_supply_low_i, // [RULE13]
		rotor_halt_i,                                // [RULE14]
		open_load_b_i,                               // [RULE14]
		open_load_a_i,                               // [RULE14]
		overcurrent_i                                // [RULE10]
	};

	// sticky flags, a new event wins over the clear
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fault_bits <= FAULT_POR[14:0]; // power-on shows all ones
		end else if (diag_clear) begin
			fault_bits <= fault_events; // [RULE19]
		end else begin
			fault_bits <= fault_bits | fault_events; // [RULE10]
		end
	end

	// serial error memory
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			serial_err   <= 1'b1;
			parity_err_o <= 1'b0;
		end else begin
			serial_err   <= (serial_err && !diag_clear) || ser_write_err_i
				|| (is_table && !parity_ok); // [RULE18]
			parity_err_o <= (parity_err_o && !diag_clear)
				|| (is_table && !parity_ok); // [RULE22]
		end
	end

	// register images and plain outputs
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fault_flags_primary_o    <= FAULT_POR;
			fault_flags_with_angle_o <= {FAULT_POR[15:8], 2'h0, ANGLE_RESET};
			decay_select_o           <= DECAY_RESET;
			step_angle_o             <= ANGLE_RESET;
		end else begin
			fault_flags_primary_o    <= {(|fault_bits) | serial_err, fault_bits}; // [RULE18]
			fault_flags_with_angle_o <= {(|fault_bits) | serial_err,
				fault_bits[14:F_OC_HI + 1], 2'h0, step_angle}; // [RULE11]
			decay_select_o           <= decay_select;
			step_angle_o             <= step_angle;
		end
	end

endmodule

// [shared/spt_pkg.sv]
// shared constants and types for the step angle, phase table and fault logic
package spt_pkg;

	// ----------------------------------------------------------------
	// serial word layout
	// ----------------------------------------------------------------
	localparam int          WORD_W       = 16;
	localparam int          ID_HI        = 15;
	localparam int          ID_LO        = 14;
	localparam logic [1:0]  ID_RUN       = 2'h2;
	localparam logic [1:0]  ID_TABLE     = 2'h3;
	localparam int          DECAY_HI     = 7;
	localparam int          DECAY_LO     = 6;
	localparam int          DELTA_HI     = 5;
	localparam int          DELTA_LO     = 0;
	localparam int          PARITY_BIT   = 6;
	localparam int          ENTRY_HI     = 5;
	localparam int          ENTRY_LO     = 0;

	// ----------------------------------------------------------------
	// angle and table geometry
	// ----------------------------------------------------------------
	localparam int          ANGLE_W      = 6;
	localparam int          MAG_W        = 6;
	localparam int          ENTRIES      = 16;
	localparam int          IDX_W        = 4;
	localparam logic [5:0]  QUARTER      = 6'h10;
	localparam logic [5:0]  FULL_OFFSET  = 6'h08;
	localparam logic [4:0]  HALF_ZERO    = 5'h00;
	localparam logic [4:0]  HALF_PEAK    = 5'h10;
	localparam logic [4:0]  HALF_MIRROR  = 5'h1F;
	localparam logic [5:0]  MAG_DEFAULT  = 6'h20;
	localparam logic [5:0]  ANGLE_RESET  = 6'h00;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [1:0]  DECAY_RESET  = 2'h1;
	localparam logic [15:0] FAULT_POR    = 16'hFFFF;
	localparam logic [15:0] FAULT_CLEAR  = 16'h0000;

	// ----------------------------------------------------------------
	// fault register 0 bit positions
	// ----------------------------------------------------------------
	localparam int          F_SUMMARY    = 15;
	localparam int          F_THERM_HI   = 14;
	localparam int          F_THERM_LO   = 13;
	localparam int          F_SUP_HIGH   = 12;
	localparam int          F_SUP_LOW    = 11;
	localparam int          F_HALT       = 10;
	localparam int          F_OPEN_B     = 9;
	localparam int          F_OPEN_A     = 8;
	localparam int          F_OC_HI      = 7;
	localparam int          F1_ANGLE_HI  = 5;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int          CLK_PERIOD_PS = 5000;
	localparam int          RST_PULSE_NS  = 1;
	localparam int          RST_CYCLES    =
		(RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int          RST_CNT_W     = 8;

	// ----------------------------------------------------------------
	// modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SPT_DECAY_SLOW,
		SPT_DECAY_MIXED_FIXED,
		SPT_DECAY_MIXED_AUTO,
		SPT_DECAY_FAST
	} spt_decay_e;

	typedef enum logic [1:0] {
		SPT_MS_FULL,
		SPT_MS_HALF,
		SPT_MS_QUARTER,
		SPT_MS_SIXTEENTH
	} spt_microstep_e;

	typedef enum logic [1:0] {
		SPT_THERM_NONE,
		SPT_THERM_COLD,
		SPT_THERM_HOT,
		SPT_THERM_SHUTDOWN
	} spt_thermal_e;

endpackage

// [shared/spt_table_if.sv]
// carrier between the step logic and the phase table memory
`timescale 1ns/1ps
interface spt_table_if;
	import spt_pkg::*;
	logic             wr_en;
	logic [IDX_W-1:0] wr_idx;
	logic [MAG_W-1:0] wr_mag;
	logic [IDX_W-1:0] rd_idx_a;
	logic [IDX_W-1:0] rd_idx_b;
	logic [MAG_W-1:0] rd_mag_a;
	logic [MAG_W-1:0] rd_mag_b;

	modport mem (
		input  wr_en, wr_idx, wr_mag, rd_idx_a, rd_idx_b,
		output rd_mag_a, rd_mag_b
	);
	modport core (
		output wr_en, wr_idx, wr_mag, rd_idx_a, rd_idx_b,
		input  rd_mag_a, rd_mag_b
	);
endinterface

// [src/spt_table_mem.sv]
// sixteen entry phase magnitude store with two registered read ports
`timescale 1ns/1ps
module spt_table_mem
	import spt_pkg::*;
(
	input  wire logic sys_clk_i,
	input  wire logic rstn_i,
	spt_table_if.mem  tbl
);

	logic [MAG_W-1:0] entry [ENTRIES];

	// ----------------------------------------------------------------
	// storage, defaults only on power-on reset [RULE20]
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < ENTRIES; g++) begin : gen_entry
			always_ff @(posedge sys_clk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					entry[g] <= MAG_DEFAULT;
				end else if (tbl.wr_en && tbl.wr_idx == IDX_W'(g)) begin
					entry[g] <= tbl.wr_mag;
				end
			end
		end
	endgenerate

	// registered reads for both phases
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tbl.rd_mag_a <= '0;
			tbl.rd_mag_b <= '0;
		end else begin
			tbl.rd_mag_a <= entry[tbl.rd_idx_a];
			tbl.rd_mag_b <= entry[tbl.rd_idx_b];
		end
	end

endmodule

// [sim/spt_core_monitor.sv]
// assertion checker on the ports of the step angle, table and fault block
`timescale 1ns/1ps
module spt_core_monitor
	import spt_pkg::*;
(
	input wire logic              sys_clk_i,
	input wire logic              rstn_i,
	input wire logic              reset_pin_n_i,
	input wire logic [WORD_W-1:0] ser_word_i,
	input wire logic              ser_write_i,
	input wire logic              ser_access_done_i,
	input wire logic              step_i,
	input wire logic              dir_i,
	input wire logic [1:0]        microstep_i,
	input wire logic [1:0]        thermal_i,
	input wire logic              supply_high_i,
	input wire logic              motor_supply_low_i,
	input wire logic              regulator_supply_low_i,
	input wire logic              rotor_halt_i,
	input wire logic              open_load_a_i,
	input wire logic              open_load_b_i,
	input wire logic [7:0]        overcurrent_i,
	input wire logic [1:0]        decay_select_o,
	input wire logic [ANGLE_W-1:0] step_angle_o,
	input wire logic [WORD_W-1:0] fault_flags_primary_o,
	input wire logic [WORD_W-1:0] fault_flags_with_angle_o,
	input wire logic              parity_err_o
);
	logic [1:0]  hi_cnt;
	logic        pin_ok;
	logic [12:0] ev;
	// edges since the reset pin was last low
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			hi_cnt <= 2'h3;
		else if (!reset_pin_n_i)
			hi_cnt <= 2'h0;
		else if (hi_cnt != 2'h3)
			hi_cnt <= hi_cnt + 2'h1;
	end
	// pin settled high; events in fault bit order
	assign pin_ok = reset_pin_n_i && hi_cnt == 2'h3;
	assign ev = {supply_high_i, motor_supply_low_i | regulator_supply_low_i, rotor_halt_i,
		open_load_b_i, open_load_a_i, overcurrent_i};
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);
	sequence s_run;
		ser_write_i && ser_word_i[15:14] == 2'h2 && pin_ok;
	endsequence
	sequence s_bad_tbl;
		ser_write_i && ser_word_i[15:14] == 2'h3 && !(^ser_word_i) && pin_ok;
	endsequence
	sequence s_idle;
		!(ser_write_i && ser_word_i[15:14] == 2'h2) && !$rose(step_i) && pin_ok;
	endsequence
	sequence s_fine;
		$rose(step_i) && microstep_i == 2'h3 && !ser_write_i && pin_ok;
	endsequence
	a_run_delta_add: assert property (
		s_run |-> ##2 step_angle_o == $past(step_angle_o) + $past(ser_word_i[5:0], 2))
		else $error("angle did not move by the run delta");
	a_run_decay_set: assert property (
		s_run |-> ##2 decay_select_o == $past(ser_word_i[7:6], 2))
		else $error("decay select not taken from run word");
	a_fine_step_one: assert property (
		s_fine |-> ##2 step_angle_o == $past(step_angle_o) + ($past(dir_i, 2) ? 6'h01 : 6'h3F))
		else $error("sixteenth step did not move by one");
	a_angle_held: assert property (
		s_idle |-> ##2 $stable(step_angle_o))
		else $error("angle moved without a cause");
	a_parity_reject: assert property (
		s_bad_tbl |=> parity_err_o ##1 fault_flags_primary_o[15])
		else $error("even parity table word not flagged");
	a_summary_any: assert property (
		|fault_flags_primary_o[14:0] |-> fault_flags_primary_o[15] && fault_flags_with_angle_o[15])
		else $error("summary low while a fault is set");
	a_f1_layout: assert property (
		fault_flags_with_angle_o[15:6] == {fault_flags_primary_o[15:8], 2'h0})
		else $error("second fault register layout wrong");
	a_events_kept: assert property (
		|ev |-> ##2 (fault_flags_primary_o[12:0] & $past(ev, 2)) == $past(ev, 2))
		else $error("fault event not latched in its bit");
	a_thermal_code: assert property (
		thermal_i != 2'h0 |-> ##2
			(fault_flags_primary_o[14:13] & $past(thermal_i, 2)) == $past(thermal_i, 2))
		else $error("thermal code not latched");
	a_access_clear: assert property (
		ser_access_done_i && ev == 13'h0000 && thermal_i == 2'h0 |->
			##2 fault_flags_primary_o[14:0] == 15'h0000)
		else $error("diagnostics not cleared after access");
endmodule

// [sim/spt_ctrl_model.sv]
// serial controller model: frames run, table and access words into the block
`timescale 1ns/1ps
module spt_ctrl_model
	import spt_pkg::*;
(
	input  wire logic         sys_clk_i,
	output logic [WORD_W-1:0] ser_word_o,
	output logic              ser_write_o,
	output logic              ser_access_done_o,
	output logic              ser_write_err_o
);
	// idle lines at time zero
	initial begin
		ser_word_o = 16'h0000;
		ser_write_o = 1'b0;
		ser_access_done_o = 1'b0;
		ser_write_err_o = 1'b0;
	end
	// table word with tag and odd parity, or broken parity on request
	function automatic logic [WORD_W-1:0] tbl_word(input logic [5:0] m, input logic bad);
		return {2'h3, 7'h00, ~(^m) ^ bad, m};
	endfunction
	// one strobe per word; released bus shows the inverse, not the word
	task automatic send(input logic [WORD_W-1:0] w, input logic wr, input logic dn);
		@(posedge sys_clk_i);
		ser_word_o <= w;
		ser_write_o <= wr;
		ser_access_done_o <= dn;
		@(posedge sys_clk_i);
		ser_word_o <= ~w;
		ser_write_o <= 1'b0;
		ser_access_done_o <= 1'b0;
		repeat (6) @(posedge sys_clk_i); // gap to any step pulse
	endtask
	// one-cycle framing error report from the serial front end
	task automatic fault_frame();
		@(posedge sys_clk_i);
		ser_write_err_o <= 1'b1;
		@(posedge sys_clk_i);
		ser_write_err_o <= 1'b0;
	endtask
endmodule

// [sim/spt_core_test.sv]
// self-checking bench for the step angle, table and fault block
`timescale 1ns/1ps
module spt_core_test;
	import spt_pkg::*;
	logic              sys_clk_i, rstn_i, reset_pin_n_i, ser_write_i, ser_access_done_i;
	logic              ser_write_err_i, step_i, dir_i, supply_high_i, motor_supply_low_i;
	logic              regulator_supply_low_i, rotor_halt_i, open_load_a_i, open_load_b_i;
	logic              phase_a_neg_o, phase_b_neg_o, parity_err_o, perr;
	logic [1:0]        microstep_i, thermal_i, decay_select_o, look, decay;
	logic [7:0]        overcurrent_i, seed;
	logic [5:0]        step_angle_o, phase_a_mag_o, phase_b_mag_o, ang;
	logic [WORD_W-1:0] ser_word_i, fault_flags_primary_o, fault_flags_with_angle_o;
	logic [5:0]        tbl [16];
	logic [31:0]       q [$];
	int                error_cnt, checks_done;

	spt_core #(.RST_LOW_CYCLES(3)) dut_u (.*);
	spt_ctrl_model ctl_u (.sys_clk_i(sys_clk_i), .ser_word_o(ser_word_i),
		.ser_write_o(ser_write_i), .ser_access_done_o(ser_access_done_i),
		.ser_write_err_o(ser_write_err_i));

	// 200 MHz clock
	initial begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// expected magnitude of phase a at angle n
	function automatic logic [5:0] mag(input logic [5:0] n);
		if (n[4:0] == 5'h00) return 6'h00;
		if (n[4:0] == 5'h10) return tbl[15];
		return n[4:0] < 5'h10 ? tbl[n[3:0] - 4'h1] : tbl[4'hF - n[3:0]];
	endfunction
	// translator grid point for a step in mode ms
	function automatic logic [5:0] grid(input logic [5:0] a, input logic [1:0] ms, input logic fw);
		int g, o, t;
		g = ms == 2'h0 ? 16 : ms == 2'h1 ? 8 : ms == 2'h2 ? 4 : 1;
		o = ms == 2'h0 ? 8 : 0;
		t = (a + 64 - o) % 64;
		t = fw ? (t / g + 1) * g : (t % g == 0 ? t - g : t / g * g);
		return 6'((t + o + 64) % 64);
	endfunction
	task automatic end_sim();
		if (error_cnt == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// one compare per kind of result; an unknown never matches
	task automatic cmp_state(input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD state exp %h got %h", e, g);
		end
	endtask
	task automatic cmp_faults(input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD faults exp %h got %h", e, g);
		end
	endtask
	// let the result settle, note it, and flag the watcher
	task automatic note(input logic [31:0] e, input logic [1:0] k);
		repeat (6) @(posedge sys_clk_i);
		q.push_back(e);
		look <= k;
		@(posedge sys_clk_i);
		look <= 2'h0;
	endtask
	task automatic expect_state();
		note({1'b0, perr, decay, ang, mag(ang), ang > 6'h20, mag(ang + 6'h10),
			ang > 6'h10 && ang < 6'h30, 2'h0, ang}, 2'h1);
	endtask
	task automatic run(input logic [1:0] d, input logic [5:0] dl);
		ctl_u.send({2'h2, 6'h00, d, dl}, 1'b1, 1'b0);
		decay = d;
		ang = ang + dl;
		expect_state();
	endtask
	task automatic step(input logic [1:0] ms, input logic dr);
		@(posedge sys_clk_i);
		microstep_i <= ms;
		dir_i <= dr;
		step_i <= 1'b1;
		@(posedge sys_clk_i);
		step_i <= 1'b0;
		ang = grid(ang, ms, dr);
		expect_state();
	endtask
	task automatic faults(input logic [1:0] th, input logic [5:0] f, input logic [7:0] oc);
		@(posedge sys_clk_i);
		thermal_i <= th;
		{supply_high_i, motor_supply_low_i, regulator_supply_low_i, rotor_halt_i, open_load_b_i,
			open_load_a_i} <= f;
		overcurrent_i <= oc;
	endtask
	// what the block shows, packed like the notes
	logic [31:0]       state_seen, faults_seen;
	assign state_seen = {1'b0, parity_err_o, decay_select_o, step_angle_o, phase_a_mag_o,
		phase_a_neg_o, phase_b_mag_o, phase_b_neg_o, fault_flags_with_angle_o[7:0]};
	assign faults_seen = {8'h00, fault_flags_with_angle_o[15:8], fault_flags_primary_o};
	// watcher: pair each settled result with the oldest note
	always @(posedge sys_clk_i) begin
		if (look == 2'h1)
			cmp_state(q.pop_front(), state_seen);
		if (look == 2'h2)
			cmp_faults(q.pop_front(), faults_seen);
	end
	// watchdog
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		error_cnt++;
		end_sim();
	end
	// main sequence
	initial begin
		{rstn_i, step_i, dir_i, look, perr, ang} = '0;
		{reset_pin_n_i, microstep_i, decay, seed} = {1'b1, 2'h3, 2'h1, 8'h12};
		faults(2'h0, 6'h00, 8'h00);
		for (int i = 0; i < 16; i++)
			tbl[i] = MAG_DEFAULT;
		repeat (7) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		expect_state();
		note(32'h00FF_FFFF, 2'h2);
		ctl_u.send(16'h0000, 1'b0, 1'b1);
		note(32'h0, 2'h2);
		for (int i = 0; i < 16; i++) begin
			seed = lfsr(seed);
			tbl[i] = seed[5:0];
			ctl_u.send(ctl_u.tbl_word(seed[5:0], 1'b0), 1'b1, 1'b0);
		end
		for (int i = 0; i < 64; i++)
			step(2'h3, 1'b1);
		for (int i = 0; i < 12; i++) begin
			seed = lfsr(seed);
			run(i[1:0], seed[5:0]);
		end
		for (int i = 0; i < 8; i++)
			step(i[2:1], i[0]);
		faults(2'h2, 6'h0A, 8'hA5);
		note(32'h00CA_CAA5, 2'h2);
		faults(2'h1, 6'h35, 8'h5A);
		note(32'h00FF_FFFF, 2'h2);
		faults(2'h0, 6'h00, 8'h00);
		ctl_u.send(16'h0000, 1'b0, 1'b1);
		note(32'h0, 2'h2);
		ctl_u.fault_frame();
		note(32'h0080_8000, 2'h2);
		reset_pin_n_i <= 1'b0;
		repeat (5) @(posedge sys_clk_i);
		reset_pin_n_i <= 1'b1;
		{ang, decay} = {6'h00, DECAY_RESET};
		expect_state();
		note(32'h0, 2'h2);
		ctl_u.send(ctl_u.tbl_word(6'h3F, 1'b1), 1'b1, 1'b0);
		perr = 1'b1;
		ctl_u.send(ctl_u.tbl_word(6'h15, 1'b0), 1'b1, 1'b0);
		tbl[0] = 6'h15;
		run(2'h3, 6'h01);
		@(posedge sys_clk_i);
		end_sim();
	end
endmodule
bind spt_core spt_core_monitor mon_u (.*);
